// ==== rtl/ptac_map.vh ====
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide registers on a plain strobe port
// Notes:   included by the control design file and the bench files; the timeout counter file does not include it
`ifndef PTAC_MAP_VH
`define PTAC_MAP_VH

// ****************************************************************
// register offsets (12-bit byte addresses)
// ****************************************************************
`define PTAC_ID_TMO_OFS      12'h028
`define PTAC_EOM_TMO_OFS     12'h029
`define PTAC_LIMIT_OFS       12'h02A
`define PTAC_DELAY_OFS       12'h02B
`define PTAC_AFC_CFG_OFS     12'hD2C
`define PTAC_CMD_OFS         12'hD30
`define PTAC_STATUS_OFS      12'hD31

// ****************************************************************
// reset values
// ****************************************************************
`define PTAC_ID_TMO_RST      8'h00
`define PTAC_EOM_TMO_RST     8'h00
`define PTAC_LIMIT_RST       4'h2
`define PTAC_DELAY_RST       8'h00
`define PTAC_AFC_CFG_RST     7'h00

// ****************************************************************
// field positions in the start and freeze configuration and the command register
// ****************************************************************
`define PTAC_START_LSB       0
`define PTAC_START_MSB       1
`define PTAC_FREEZE_LSB      2
`define PTAC_FREEZE_MSB      4
`define PTAC_RESTART_BIT     5
`define PTAC_BLOCK_ASK_BIT   6
`define PTAC_MANF_BIT        0

// ****************************************************************
// selector codes
// ****************************************************************
`define PTAC_START_OFF       2'h0
`define PTAC_START_DIRECT    2'h1
`define PTAC_START_RSSI      2'h2
`define PTAC_START_SIGREC    2'h3
`define PTAC_FRZ_RUN         3'h0
`define PTAC_FRZ_RSSI        3'h1
`define PTAC_FRZ_SIGREC      3'h2
`define PTAC_FRZ_SYNC        3'h3
`define PTAC_FRZ_MANUAL      3'h4

// ****************************************************************
// timing: timeout tick is 64 * 512 system clocks
// ****************************************************************
`define PTAC_TMO_PRE         64
`define PTAC_TMO_BASE        512
`define PTAC_TMO_TICK        (`PTAC_TMO_PRE * `PTAC_TMO_BASE)
`define PTAC_EOM_MULT        2
`define PTAC_DLY_PREDIV      4
`define PTAC_LIMIT_SHIFT     10

`endif

// ==== rtl/ptac_tmo.v ====
// Purpose: one supervision timeout counter
// Assumes: tick is a one-cycle pulse every TICK_CYC cycles of the caller
// Notes:   setting zero disables; restart clears the count
module ptac_tmo #(
    parameter MULT = 1
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control
    input  wire       restart,
    input  wire       armed,
    input  wire       tick,
    input  wire [7:0] setting,
    // result
    output reg        expired_q
);

    // ****************************************************************
    // tick counter
    // ****************************************************************
    reg  [8:0] cnt_q;                        // elapsed ticks
    wire [8:0] limit = setting * MULT[8:0];  // ticks until expiry

    // count while armed, clear at each new cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= 9'h000;
            expired_q <= 1'b0;
        end else if (restart || !armed) begin
            cnt_q     <= 9'h000;
            expired_q <= 1'b0;
        end else if (setting != 8'h00 && tick && !expired_q) begin
            if (cnt_q + 9'h001 >= limit) begin
                expired_q <= 1'b1;
            end
            cnt_q <= cnt_q + 9'h001;
        end
    end

endmodule // ptac_tmo

// ==== rtl/ptac_ctrl.v ====
// Purpose: polling supervision timeouts and frequency-control start/freeze
// Assumes: all status inputs synchronous to clk; one-cycle event pulses
// Notes:   correction input is a signed offset in units of fsys/2^22 Hz
`include "ptac_map.vh"
module ptac_ctrl #(
    parameter TICK_CYC = `PTAC_TMO_TICK,
    parameter CW       = 16
) (
    // clock and reset
    input  wire          clk,
    input  wire          arst_n,
    // register port
    input  wire [11:0]   addr,
    input  wire [7:0]    wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [7:0]    rdata_q,
    // polling sequencer status
    input  wire          cycle_start,
    input  wire          run_self_poll,
    input  wire          symbol_sync,
    input  wire          tsi_found,
    input  wire          eom_found,
    output reg           return_to_poll_q,
    // frequency control events
    input  wire          config_start,
    input  wire          hold_exit,
    input  wire          pll_hold_init_bit,
    input  wire          rssi_event,
    input  wire          sigrec_event,
    input  wire          sync_event,
    input  wire          predec_strobe,
    input  wire          ask_low,
    // correction path
    input  wire [CW-1:0] corr_in,
    output reg  [CW-1:0] corr_q,
    output reg           afc_active_q
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    reg rst_s1_q;                            // first release stage
    reg rst_n_q;                             // released reset

    // two-stage reset release
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [7:0] id_tmo_q;                      // identifier timeout setting
    reg [7:0] eom_tmo_q;                     // message timeout setting
    reg [3:0] limit_q;                       // offset saturation limit
    reg [7:0] dly_ratio_q;                   // freeze delay ratio
    reg [6:0] cfg_q;                         // start/freeze configuration
    reg       manf_q;                        // manual freeze command
    reg       frozen_q;                      // control frozen
    wire      id_exp;                        // identifier timeout expired
    wire      eom_exp;                       // message timeout expired

    wire [1:0] start_sel  = cfg_q[`PTAC_START_MSB:`PTAC_START_LSB];
    wire [2:0] freeze_sel = cfg_q[`PTAC_FREEZE_MSB:`PTAC_FREEZE_LSB];
    wire       restart_en = cfg_q[`PTAC_RESTART_BIT];
    wire       block_ask  = cfg_q[`PTAC_BLOCK_ASK_BIT];

    // register writes
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            id_tmo_q    <= `PTAC_ID_TMO_RST;
            eom_tmo_q   <= `PTAC_EOM_TMO_RST;
            limit_q     <= `PTAC_LIMIT_RST;
            dly_ratio_q <= `PTAC_DELAY_RST;
            cfg_q       <= `PTAC_AFC_CFG_RST;
            manf_q      <= 1'b0;
        end else if (wr) begin
            case (addr)
                `PTAC_ID_TMO_OFS:  id_tmo_q    <= wdata;
                `PTAC_EOM_TMO_OFS: eom_tmo_q   <= wdata;
                `PTAC_LIMIT_OFS:   limit_q     <= wdata[3:0];
                `PTAC_DELAY_OFS:   dly_ratio_q <= wdata;
                `PTAC_AFC_CFG_OFS: cfg_q       <= wdata[6:0];
                `PTAC_CMD_OFS:     manf_q      <= wdata[`PTAC_MANF_BIT];
                default:           manf_q      <= manf_q;
            endcase
        end
    end

    // ****************************************************************
    // read path: data stand one cycle after the strobe
    // ****************************************************************
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                `PTAC_ID_TMO_OFS:  rdata_q <= id_tmo_q;
                `PTAC_EOM_TMO_OFS: rdata_q <= eom_tmo_q;
                `PTAC_LIMIT_OFS:   rdata_q <= {4'h0, limit_q};
                `PTAC_DELAY_OFS:   rdata_q <= dly_ratio_q;
                `PTAC_AFC_CFG_OFS: rdata_q <= {1'b0, cfg_q};
                `PTAC_CMD_OFS:     rdata_q <= {7'h00, manf_q};
                `PTAC_STATUS_OFS:  rdata_q <= {4'h0, frozen_q, afc_active_q,
                                               eom_exp, id_exp};
                default:           rdata_q <= 8'h00;  // unmapped reads zero
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ****************************************************************
    // supervision timeouts
    // ****************************************************************
    localparam TW = $clog2(TICK_CYC);
    reg  [TW-1:0] pre_q;                     // 64*512 clock prescaler
    wire          tick = (pre_q == TICK_CYC[TW-1:0] - 1'b1);
    reg           tsi_seen_q;                // identifier seen this cycle

    // prescaler restarts with each polling cycle
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_q <= {TW{1'b0}};
        end else if (cycle_start || tick) begin
            pre_q <= {TW{1'b0}};
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // remember the identifier until the message end
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tsi_seen_q <= 1'b0;
        end else if (tsi_found) begin
            tsi_seen_q <= 1'b1;              // set wins over clear
        end else if (cycle_start || !run_self_poll || eom_found) begin
            tsi_seen_q <= 1'b0;
        end
    end

    // identifier timeout: armed after sync until identifier
    ptac_tmo #(.MULT(1)) u_id_tmo (
        .clk       (clk),
        .rst_n     (rst_n_q),
        .restart   (cycle_start),
        .armed     (run_self_poll && symbol_sync && !tsi_seen_q),
        .tick      (tick),
        .setting   (id_tmo_q),
        .expired_q (id_exp)
    );

    // message timeout: armed after identifier; doubled length
    ptac_tmo #(.MULT(`PTAC_EOM_MULT)) u_eom_tmo (
        .clk       (clk),
        .rst_n     (rst_n_q),
        .restart   (cycle_start || eom_found),
        .armed     (run_self_poll && tsi_seen_q),
        .tick      (tick),
        .setting   (eom_tmo_q),
        .expired_q (eom_exp)
    );

    // one-cycle request to return to self polling
    reg exp_d1_q;                            // previous expiry state
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            exp_d1_q         <= 1'b0;
            return_to_poll_q <= 1'b0;
        end else begin
            exp_d1_q         <= id_exp || eom_exp;
            return_to_poll_q <= (id_exp || eom_exp) && !exp_d1_q;
        end
    end

    // ****************************************************************
    // freeze delay counter
    // ****************************************************************
    reg [1:0] pdiv_q;                        // strobe divided by four
    reg [7:0] dly_cnt_q;                     // delay units elapsed
    reg       dly_run_q;                     // delay in progress
    wire      dly_tick = predec_strobe && (pdiv_q == 2'h3);

    // freeze trigger from selector
    reg frz_evt;
    always @* begin
        case (freeze_sel)
            `PTAC_FRZ_RSSI:   frz_evt = rssi_event;
            `PTAC_FRZ_SIGREC: frz_evt = sigrec_event;
            `PTAC_FRZ_SYNC:   frz_evt = sync_event;
            default:          frz_evt = 1'b0;
        endcase
    end

    // start trigger from selector
    reg start_evt;
    always @* begin
        case (start_sel)
            `PTAC_START_DIRECT: start_evt = 1'b1;
            `PTAC_START_RSSI:   start_evt = rssi_event;
            `PTAC_START_SIGREC: start_evt = sigrec_event;
            default:            start_evt = 1'b0;
        endcase
    end

    wire restart = restart_en &&
                   (config_start || (hold_exit && pll_hold_init_bit));

    // delay run and freeze state
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pdiv_q    <= 2'h0;
            dly_cnt_q <= 8'h00;
            dly_run_q <= 1'b0;
            frozen_q  <= 1'b0;
        end else if (restart) begin
            pdiv_q    <= 2'h0;
            dly_cnt_q <= 8'h00;
            dly_run_q <= 1'b0;
            frozen_q  <= 1'b0;
        end else begin
            if (predec_strobe) begin
                pdiv_q <= pdiv_q + 2'h1;
            end
            if (freeze_sel == `PTAC_FRZ_MANUAL) begin
                frozen_q <= manf_q;
            end else if (freeze_sel == `PTAC_FRZ_RUN) begin
                frozen_q <= 1'b0;
            end else if (frz_evt && !dly_run_q && !frozen_q) begin
                dly_run_q <= 1'b1;
                dly_cnt_q <= 8'h00;
                if (dly_ratio_q == 8'h00) begin
                    dly_run_q <= 1'b0;
                    frozen_q  <= 1'b1;
                end
            end else if (dly_run_q && dly_tick) begin
                if (dly_cnt_q + 8'h01 >= dly_ratio_q) begin
                    dly_run_q <= 1'b0;
                    frozen_q  <= 1'b1;
                end
                dly_cnt_q <= dly_cnt_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // correction output with saturation
    // ****************************************************************
    wire signed [CW-1:0] lim_pos = $signed({{(CW-4){1'b0}}, limit_q})
                                   <<< `PTAC_LIMIT_SHIFT;
    wire signed [CW-1:0] lim_neg = -lim_pos;
    wire signed [CW-1:0] cin     = corr_in;
    reg  signed [CW-1:0] sat;

    // clamp to the configured limit
    always @* begin
        if (cin > lim_pos) begin
            sat = lim_pos;
        end else if (cin < lim_neg) begin
            sat = lim_neg;
        end else begin
            sat = cin;
        end
    end

    // activity and update of the correction
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            afc_active_q <= 1'b0;
            corr_q       <= {CW{1'b0}};
        end else begin
            if (start_sel == `PTAC_START_OFF) begin
                afc_active_q <= 1'b0;
            end else if (restart) begin
                afc_active_q <= (start_sel == `PTAC_START_DIRECT);
            end else if (start_evt) begin
                afc_active_q <= 1'b1;
            end
            if (limit_q == 4'h0 || start_sel == `PTAC_START_OFF) begin
                corr_q <= {CW{1'b0}};
            end else if (afc_active_q && !frozen_q &&
                         !(block_ask && ask_low)) begin
                corr_q <= sat;
            end else begin
                corr_q <= corr_q;
            end
        end
    end

endmodule // ptac_ctrl

// ==== tb/ptac_ctrl_chk.sv ====
// Purpose: port-level checks of the polling timeout and freq control block
// Assumes: sees only ptac_ctrl ports; keeps shadows of written registers
// Notes:   bound to the design from the bench top file
`include "ptac_map.vh"
module ptac_ctrl_chk #(
    parameter int TICK_CYC = 4,
    parameter int CW       = 16
) (
    // clock and reset
    input wire logic          clk,
    input wire logic          arst_n,
    // register port
    input wire logic [11:0]   addr,
    input wire logic [7:0]    wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [7:0]    rdata_q,
    // status and correction
    input wire logic          ask_low,
    input wire logic          return_to_poll_q,
    input wire logic [CW-1:0] corr_in,
    input wire logic [CW-1:0] corr_q,
    input wire logic          afc_active_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ****************************************************
    // register shadows
    // ****************************************************
    logic [7:0] id_q;       // identifier timeout setting
    logic [7:0] eom_q;      // message timeout setting
    logic [3:0] lim_q;      // saturation limit
    logic [6:0] cfg_q;      // start and freeze configuration
    logic       frz_seen_q; // a freeze code was set last cycle
    // follow writes to the timeout, limit and configuration registers, as the design must
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            id_q       <= 8'h00;
            eom_q      <= 8'h00;
            lim_q      <= 4'h2;
            cfg_q      <= 7'h00;
            frz_seen_q <= 1'b0;
        end else begin
            if (wr && addr == `PTAC_ID_TMO_OFS) id_q <= wdata;
            if (wr && addr == `PTAC_EOM_TMO_OFS) eom_q <= wdata;
            if (wr && addr == `PTAC_LIMIT_OFS) lim_q <= wdata[3:0];
            if (wr && addr == `PTAC_AFC_CFG_OFS) cfg_q <= wdata[6:0];
            frz_seen_q <= (cfg_q[4:2] != 3'h0);
        end
    end
    // clamp a raw correction to plus or minus limit*1024
    function automatic logic [CW-1:0] sat(input logic [CW-1:0] v,
                                          input logic [3:0]    l);
        int m;
        int x;
        m = int'(l) << `PTAC_LIMIT_SHIFT;
        x = int'($signed(v));
        if (x > m) x = m;
        if (x < -m) x = -m;
        return x[CW-1:0];
    endfunction
    // ****************************************************
    // assertions
    // ****************************************************
    property p_rdata_idle;
        !$past(rd) |-> rdata_q == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside the read cycle");
    property p_rtp_pulse;
        return_to_poll_q |=> !return_to_poll_q;
    endproperty
    a_rtp_pulse: assert property (p_rtp_pulse)
        else $error("return pulse longer than one cycle");
    property p_rtp_off;
        return_to_poll_q |-> $past(id_q) != 8'h00 || $past(eom_q) != 8'h00;
    endproperty
    a_rtp_off: assert property (p_rtp_off)
        else $error("timeout fired with both settings zero");
    property p_sat_bound;
        corr_q != $past(corr_q) |-> corr_q == sat(corr_q, $past(lim_q));
    endproperty
    a_sat_bound: assert property (p_sat_bound)
        else $error("correction beyond the limit");
    property p_off_zero;
        $past(cfg_q[1:0], 2) == 2'h0 && $past(cfg_q[1:0]) == 2'h0
            |-> corr_q == '0 && !afc_active_q;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("control active while switched off");
    property p_direct_on;
        wr && addr == `PTAC_AFC_CFG_OFS && wdata[1:0] == 2'h1
            |-> ##[1:2] afc_active_q;
    endproperty
    a_direct_on: assert property (p_direct_on)
        else $error("direct start did not activate");
    property p_track;
        afc_active_q && !frz_seen_q && !cfg_q[6] && cfg_q[1:0] != 2'h0 && !wr
            |=> corr_q == sat($past(corr_in), $past(lim_q));
    endproperty
    a_track: assert property (p_track)
        else $error("correction not following input");
    property p_block;
        afc_active_q && cfg_q[6] && ask_low && !wr |=> $stable(corr_q);
    endproperty
    a_block: assert property (p_block)
        else $error("correction moved during ask low");
endmodule // ptac_ctrl_chk

// ==== tb/ptac_ctrl_bench.sv ====
// Purpose: self-checking bench of the timeout and freq control block
// Assumes: short timeout tick of 4 clocks; strobe every second clock
// Notes:   every scenario is a task that judges its own results
`include "ptac_map.vh"
module ptac_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;      // system clock
    logic        arst_n = 1'b0;   // async reset
    logic [11:0] addr = 12'h000;  // register port
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata_q;
    logic [7:0]  pls = 8'h00;     // event pulses, one bit each
    logic        run_sp = 1'b0;   // run mode self polling
    logic        sync = 1'b0;     // symbol sync level
    logic        pllh = 1'b0;     // pll hold init bit
    logic        ask_low = 1'b0;
    logic        predec = 1'b0;
    logic [15:0] corr_in = 16'h0000;
    logic [15:0] corr_q;
    logic        rtp_q;
    logic        act_q;
    int          failures = 0;
    int          compares = 0;
    always #5 clk = ~clk;
    // predecimation strobe: one pulse every two clocks
    always @(posedge clk) predec <= ~predec;
    ptac_ctrl #(.TICK_CYC(4), .CW(16)) uut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_q(rdata_q), .cycle_start(pls[0]),
        .run_self_poll(run_sp), .symbol_sync(sync), .tsi_found(pls[1]),
        .eom_found(pls[2]), .return_to_poll_q(rtp_q),
        .config_start(pls[3]), .hold_exit(pls[4]),
        .pll_hold_init_bit(pllh), .rssi_event(pls[5]),
        .sigrec_event(pls[6]), .sync_event(pls[7]), .predec_strobe(predec),
        .ask_low(ask_low), .corr_in(corr_in), .corr_q(corr_q),
        .afc_active_q(act_q));
    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata_q, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk) pls[k] <= 1'b1;
        @(posedge clk) pls[k] <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // count clocks until the return pulse, at most lim
    task automatic wait_rtp(input int lim, output int n);
        n = 0;
        while (rtp_q !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_regs;
        logic [11:0] a[6] = '{`PTAC_ID_TMO_OFS, `PTAC_EOM_TMO_OFS,
            `PTAC_LIMIT_OFS, `PTAC_DELAY_OFS, `PTAC_AFC_CFG_OFS, 12'h100};
        logic [7:0] r[6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
        logic [7:0] w[6] = '{8'hA5, 8'hA5, 8'h05, 8'hA5, 8'h25, 8'h00};
        for (int i = 0; i < 6; i++) rreg(a[i], r[i]);
        for (int i = 0; i < 6; i++) wreg(a[i], 8'hA5);
        for (int i = 0; i < 6; i++) rreg(a[i], w[i]);
        for (int i = 0; i < 5; i++) wreg(a[i], r[i]);
        $display("test registers done");
    endtask
    task automatic t_id;
        int n;
        wreg(`PTAC_ID_TMO_OFS, 8'h03);
        @(posedge clk) {run_sp, sync} <= 2'b11;
        pulse(0);
        cyc(6);
        pulse(0);
        wait_rtp(40, n);
        chk(n >= 8 && n <= 18, 1'b1);
        wreg(`PTAC_ID_TMO_OFS, 8'h00);
        pulse(0);
        wait_rtp(60, n);
        chk(n, 60);
        wreg(`PTAC_ID_TMO_OFS, 8'h01);
        @(posedge clk) sync <= 1'b0;
        pulse(0);
        wait_rtp(30, n);
        chk(n, 30);
        wreg(`PTAC_ID_TMO_OFS, 8'h00);
        $display("test identifier timeout done");
    endtask
    task automatic t_msg;
        int n;
        wreg(`PTAC_EOM_TMO_OFS, 8'h02);
        pulse(0);
        pulse(1);
        wait_rtp(50, n);
        chk(n >= 12 && n <= 22, 1'b1);
        pulse(0);
        pulse(1);
        cyc(5);
        pulse(2);
        wait_rtp(50, n);
        chk(n, 50);
        $display("test message timeout done");
    endtask
    task automatic t_track;
        logic [15:0] v[5] = '{16'd5000, -16'sd5000, 16'd1000, 16'd2049,
            -16'sd2048};
        logic [15:0] e[5] = '{16'h0800, 16'hF800, 16'd1000, 16'h0800,
            16'hF800};
        wreg(`PTAC_AFC_CFG_OFS, 8'h01);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) corr_in <= v[i];
            cyc(3);
            chk(corr_q, e[i]);
        end
        chk(act_q, 1'b1);
        wreg(`PTAC_LIMIT_OFS, 8'h0F);
        @(posedge clk) corr_in <= 16'd20000;
        cyc(3);
        chk(corr_q, 16'h3C00);
        wreg(`PTAC_LIMIT_OFS, 8'h00);
        cyc(3);
        chk(corr_q, 16'h0000);
        wreg(`PTAC_LIMIT_OFS, 8'h02);
        $display("test tracking done");
    endtask
    task automatic t_block;
        wreg(`PTAC_AFC_CFG_OFS, 8'h41);
        @(posedge clk) corr_in <= 16'd100;
        cyc(3);
        @(posedge clk) {ask_low, corr_in} <= {1'b1, 16'd200};
        cyc(3);
        chk(corr_q, 16'd100);
        @(posedge clk) ask_low <= 1'b0;
        cyc(3);
        chk(corr_q, 16'd200);
        wreg(`PTAC_AFC_CFG_OFS, 8'h01);
        @(posedge clk) {ask_low, corr_in} <= {1'b1, 16'd300};
        cyc(3);
        chk(corr_q, 16'd300);
        @(posedge clk) ask_low <= 1'b0;
        $display("test ask blocking done");
    endtask
    task automatic t_start;
        wreg(`PTAC_AFC_CFG_OFS, 8'h00);
        cyc(3);
        chk({act_q, corr_q}, 17'h0);
        wreg(`PTAC_AFC_CFG_OFS, 8'h02);
        @(posedge clk) corr_in <= 16'd700;
        cyc(3);
        chk(act_q, 1'b0);
        pulse(5);
        cyc(3);
        chk({act_q, corr_q}, {1'b1, 16'd700});
        wreg(`PTAC_AFC_CFG_OFS, 8'h00);
        wreg(`PTAC_AFC_CFG_OFS, 8'h03);
        pulse(5);
        cyc(3);
        chk(act_q, 1'b0);
        pulse(6);
        cyc(3);
        chk(act_q, 1'b1);
        $display("test start selector done");
    endtask
    task automatic t_freeze;
        logic [2:0] c[6] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h5, 3'h0};
        int         ev[6] = '{5, 6, 7, 6, 5, 7};
        logic       f[6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        wreg(`PTAC_DELAY_OFS, 8'h02);
        for (int i = 0; i < 6; i++) begin
            wreg(`PTAC_AFC_CFG_OFS, 8'h21 | {3'h0, c[i], 2'h0});
            pulse(3);
            @(posedge clk) corr_in <= 16'd300;
            cyc(3);
            pulse(ev[i]);
            cyc(4);
            @(posedge clk) corr_in <= 16'd400;
            cyc(3);
            chk(corr_q, 16'd400);
            cyc(30);
            @(posedge clk) corr_in <= 16'd500;
            cyc(3);
            chk(corr_q, f[i] ? 16'd400 : 16'd500);
        end
        wreg(`PTAC_AFC_CFG_OFS, 8'h2D);
        pulse(3);
        pulse(7);
        cyc(40);
        @(posedge clk) corr_in <= 16'd610;
        pulse(4);
        cyc(3);
        chk(corr_q, 16'd500);
        @(posedge clk) pllh <= 1'b1;
        pulse(4);
        cyc(3);
        chk(corr_q, 16'd610);
        $display("test freeze selector done");
    endtask
    task automatic t_manual;
        wreg(`PTAC_AFC_CFG_OFS, 8'h31);
        pulse(3);
        @(posedge clk) corr_in <= 16'd300;
        cyc(3);
        wreg(`PTAC_CMD_OFS, 8'h01);
        @(posedge clk) corr_in <= 16'd350;
        cyc(3);
        chk(corr_q, 16'd300);
        wreg(`PTAC_CMD_OFS, 8'h00);
        cyc(3);
        chk(corr_q, 16'd350);
        $display("test manual freeze done");
    endtask
    // main sequence
    initial begin
        cyc(20);
        arst_n <= 1'b1;
        cyc(4);
        t_regs();
        t_id();
        t_msg();
        t_track();
        t_block();
        t_start();
        t_freeze();
        t_manual();
        tally_and_finish();
    end
    // watchdog: the tests need about 800 clocks
    initial begin
        #200us;
        failures++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule // ptac_ctrl_bench
bind ptac_ctrl ptac_ctrl_chk #(.TICK_CYC(TICK_CYC), .CW(CW)) chk_i (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .ask_low(ask_low),
    .return_to_poll_q(return_to_poll_q), .corr_in(corr_in),
    .corr_q(corr_q), .afc_active_q(afc_active_q));
